// [dlc_dma.sv]
// Operation
// - eight separately set channels act as one controller, lowest number first
// - channels zero to three move bytes and count in bytes
// - channels five to seven move words and count in words
// - at most two channels may hold fast timing at once
// - channel four never transfers data; it grants a bus master
// - LPC and PC/PCI requests share one channel engine
// - PC/PCI peripherals request and receive grants on two pairs
// - LPC peripherals request on their own line; host runs cycle
// - single, demand, verify and decrement modes per channel
// - every register reads back and a written-back value restores it
`timescale 1ns/1ps
`default_nettype none

module dlc_dma
  import dlc_pkg::*;
#(
  parameter int NUM_CH = DLC_NUM_CH
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          prog_we,
  input  wire logic                          prog_cur_we,
  input  wire logic [2:0]                    prog_ch,
  input  wire dlc_cfg_s                      prog_cfg,
  output logic                               prog_refused,
  input  wire logic [2:0]                    rd_ch,
  output dlc_rd_s                            rd_data,
  input  wire logic [NUM_CH-1:0]             lpc_req,
  input  wire dlc_pci_req_s [DLC_NUM_PCI-1:0] pci_req,
  output logic [DLC_NUM_PCI-1:0]             pci_gnt,
  output logic                               xfer_valid,
  output dlc_xfer_s                          xfer,
  input  wire logic                          xfer_ack,
  output logic                               tc,
  output logic                               bm_gnt
);

  if (NUM_CH != DLC_NUM_CH) begin : g_bad_ch
    $error("dlc_dma serves exactly eight channel slots");
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel registers

  dlc_cfg_s    cfg_r     [NUM_CH];
  dlc_cfg_s    cfg_nxt   [NUM_CH];
  logic [15:0] caddr_r   [NUM_CH];
  logic [15:0] caddr_nxt [NUM_CH];
  logic [15:0] ccnt_r    [NUM_CH];
  logic [15:0] ccnt_nxt  [NUM_CH];
  dlc_state_e  state_r;
  dlc_state_e  state_nxt;
  logic [2:0]  ch_r;
  logic [2:0]  ch_nxt;
  logic        pci_r;
  logic        pci_nxt;
  logic        pidx_r;
  logic        pidx_nxt;
  logic        refused_nxt;
  logic        tc_nxt;
  dlc_rd_s     rd_nxt;
  logic [NUM_CH-1:0] req;
  logic [NUM_CH-1:0] pci_hit [DLC_NUM_PCI];
  logic [2:0]  fast_cnt;
  logic        win_vld;
  logic [2:0]  win_ch;
  logic        last;

  ////////////////////////////////////////////////////////////////////////////
  // request merge and priority

  for (genvar i = 0; i < NUM_CH; i++) begin : g_req
    for (genvar k = 0; k < DLC_NUM_PCI; k++) begin : g_pci
      assign pci_hit[k][i] = pci_req[k].req && pci_req[k].ch == 3'(i);
    end
    assign req[i] = cfg_r[i].en &&
                    (lpc_req[i] || pci_hit[0][i] || pci_hit[1][i]);
  end

  always_comb begin
    win_vld  = 1'b0;
    win_ch   = 3'h0;
    fast_cnt = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req[i]) begin
        win_vld = 1'b1;
        win_ch  = 3'(i);
      end
      if (cfg_r[i].fast && 3'(i) != prog_ch) begin
        fast_cnt = fast_cnt + 3'h1;
      end
    end
  end

  assign last = ccnt_r[ch_r] == DLC_RST_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt   = state_r;
    ch_nxt      = ch_r;
    pci_nxt     = pci_r;
    pidx_nxt    = pidx_r;
    tc_nxt      = 1'b0;
    refused_nxt = 1'b0;
    cfg_nxt     = cfg_r;
    caddr_nxt   = caddr_r;
    ccnt_nxt    = ccnt_r;
    case (state_r)
      DLC_IDLE: begin
        if (win_vld) begin
          ch_nxt   = win_ch;
          pci_nxt  = !lpc_req[win_ch];
          pidx_nxt = !pci_hit[0][win_ch];
          state_nxt = (win_ch == DLC_BM_CH) ? DLC_BM : DLC_XFER;
        end
      end
      DLC_XFER: begin
        if (xfer_ack) begin
          caddr_nxt[ch_r] = cfg_r[ch_r].decr ? caddr_r[ch_r] - 16'h1
                                             : caddr_r[ch_r] + 16'h1;
          ccnt_nxt[ch_r]  = ccnt_r[ch_r] - 16'h1;
          if (last) begin
            tc_nxt            = 1'b1;
            cfg_nxt[ch_r].en  = 1'b0;
            state_nxt         = DLC_IDLE;
          end else if (!cfg_r[ch_r].demand || !req[ch_r]) begin
            state_nxt = DLC_IDLE;
          end
        end
      end
      DLC_BM: begin
        if (!req[DLC_BM_CH]) begin
          state_nxt = DLC_IDLE;
        end
      end
      default: state_nxt = DLC_IDLE;
    endcase
    // programming; a third fast channel is refused
    if (prog_we) begin
      if (prog_cfg.fast && fast_cnt >= 3'(DLC_MAX_FAST)) begin
        refused_nxt = 1'b1;
      end else begin
        cfg_nxt[prog_ch] = prog_cfg;
        if (!prog_cur_we) begin
          caddr_nxt[prog_ch] = prog_cfg.addr;
          ccnt_nxt[prog_ch]  = prog_cfg.cnt;
        end
      end
    end
    if (prog_cur_we) begin
      caddr_nxt[prog_ch] = prog_cfg.addr;
      ccnt_nxt[prog_ch]  = prog_cfg.cnt;
    end
    rd_nxt.cfg      = cfg_r[rd_ch];
    rd_nxt.cur_addr = caddr_r[rd_ch];
    rd_nxt.cur_cnt  = ccnt_r[rd_ch];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= DLC_IDLE;
      ch_r         <= 3'h0;
      pci_r        <= 1'b0;
      pidx_r       <= 1'b0;
      tc           <= 1'b0;
      prog_refused <= 1'b0;
      rd_data      <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_r[i]   <= '0;
        caddr_r[i] <= DLC_RST_WORD;
        ccnt_r[i]  <= DLC_RST_WORD;
      end
    end else begin
      state_r      <= state_nxt;
      ch_r         <= ch_nxt;
      pci_r        <= pci_nxt;
      pidx_r       <= pidx_nxt;
      tc           <= tc_nxt;
      prog_refused <= refused_nxt;
      rd_data      <= rd_nxt;
      cfg_r        <= cfg_nxt;
      caddr_r      <= caddr_nxt;
      ccnt_r       <= ccnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign xfer_valid = state_r == DLC_XFER;
  assign bm_gnt     = state_r == DLC_BM;
  assign pci_gnt[0] = xfer_valid && pci_r && !pidx_r;
  assign pci_gnt[1] = xfer_valid && pci_r && pidx_r;

  always_comb begin
    xfer.ch        = ch_r;
    xfer.wide      = ch_r >= DLC_WIDE_LO;
    xfer.byte_addr = xfer.wide ? {caddr_r[ch_r], 1'b0}
                               : {1'b0, caddr_r[ch_r]};
    xfer.verify    = cfg_r[ch_r].verify;
    xfer.from_pci  = pci_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_bm_no_xfer;
    @(posedge sys_clk) disable iff (!rst_n)
      xfer_valid |-> ch_r != DLC_BM_CH;
  endproperty
  a_bm_no_xfer: assert property (p_bm_no_xfer)
    else $error("channel four ran a data transfer");

  property p_width;
    @(posedge sys_clk) disable iff (!rst_n)
      xfer_valid |-> xfer.wide == (ch_r > DLC_BM_CH);
  endproperty
  a_width: assert property (p_width)
    else $error("transfer width does not match channel");

  property p_fast_limit;
    @(posedge sys_clk) disable iff (!rst_n)
      prog_we && prog_cfg.fast && fast_cnt >= 3'h2
        |=> prog_refused && !cfg_r[$past(prog_ch)].fast;
  endproperty
  a_fast_limit: assert property (p_fast_limit)
    else $error("third fast channel was accepted");

  property p_count_step;
    @(posedge sys_clk) disable iff (!rst_n)
      xfer_valid && xfer_ack && !prog_cur_we && !prog_we
        |=> ccnt_r[$past(ch_r)] == $past(ccnt_r[ch_r]) - 16'h1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step by one unit");

  property p_tc;
    @(posedge sys_clk) disable iff (!rst_n)
      xfer_valid && xfer_ack && last |=> tc ##1 !tc;
  endproperty
  a_tc: assert property (p_tc)
    else $error("terminal count pulse wrong");

  property p_single;
    @(posedge sys_clk) disable iff (!rst_n)
      xfer_valid && xfer_ack && !cfg_r[ch_r].demand |=> !xfer_valid;
  endproperty
  a_single: assert property (p_single)
    else $error("single mode held the channel");

  property p_gnt_pair;
    @(posedge sys_clk) disable iff (!rst_n)
      |pci_gnt |-> xfer_valid && xfer.from_pci && !(&pci_gnt);
  endproperty
  a_gnt_pair: assert property (p_gnt_pair)
    else $error("bad PC/PCI grant");

  property p_lpc_serve;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == DLC_IDLE && win_vld && lpc_req[win_ch]
        |=> (xfer_valid && !xfer.from_pci) || bm_gnt;
  endproperty
  a_lpc_serve: assert property (p_lpc_serve)
    else $error("LPC request not served");

  property p_readback;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 rd_data.cfg == $past(cfg_r[rd_ch]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("read back differs from setup");

  property p_restore;
    @(posedge sys_clk) disable iff (!rst_n)
      prog_we && !prog_cfg.fast |=> cfg_r[$past(prog_ch)] == $past(prog_cfg);
  endproperty
  a_restore: assert property (p_restore)
    else $error("written setup not stored");

  c_lpc_xfer:  cover property (@(posedge sys_clk) xfer_valid && !pci_r
                               && xfer_ack);
  c_pci_xfer:  cover property (@(posedge sys_clk) pci_gnt[1] && xfer_ack);
  c_bm:        cover property (@(posedge sys_clk) bm_gnt);
  c_tc:        cover property (@(posedge sys_clk) tc);

endmodule : dlc_dma

`default_nettype wire

// [dlc_dma_test.sv]
`timescale 1ns/1ps
`default_nettype none

module dlc_dma_test;
  import dlc_pkg::*;
  logic                        sys_clk, rst_n, prog_we, prog_cur_we, slow;
  logic [2:0]                  prog_ch, rd_ch;
  dlc_cfg_s                    prog_cfg;
  logic                        prog_refused, xfer_valid, xfer_ack, tc, bm_gnt;
  dlc_rd_s                     rd_data;
  logic [7:0]                  lpc_req;
  dlc_pci_req_s [1:0]          pci_req;
  logic [1:0]                  pci_gnt;
  dlc_xfer_s                   xfer;
  int                          fail_count, num_checks;
  int                          ack_cnt = 0, tc_cnt = 0, ref_cnt = 0;

  dlc_dma i_dlc_dma (.sys_clk(sys_clk), .rst_n(rst_n), .prog_we(prog_we),
    .prog_cur_we(prog_cur_we), .prog_ch(prog_ch), .prog_cfg(prog_cfg),
    .prog_refused(prog_refused), .rd_ch(rd_ch), .rd_data(rd_data),
    .lpc_req(lpc_req), .pci_req(pci_req), .pci_gnt(pci_gnt),
    .xfer_valid(xfer_valid), .xfer(xfer), .xfer_ack(xfer_ack), .tc(tc),
    .bm_gnt(bm_gnt));
  dlc_host_model i_dlc_host_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .slow(slow), .xfer_valid(xfer_valid), .xfer_ack(xfer_ack));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (xfer_ack === 1'b1) ack_cnt++;
    if (tc === 1'b1) tc_cnt++;
    if (prog_refused === 1'b1) ref_cnt++;
  end

  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic prog(input logic [2:0] ch, input dlc_cfg_s c);
    prog_ch  = ch;
    prog_cfg = c;
    prog_we  = 1'b1;
    tick(1);
    prog_we  = 1'b0;
    tick(1);
  endtask : prog

  task automatic rd(input logic [2:0] ch);
    rd_ch = ch;
    tick(2);
  endtask : rd

  task automatic wait_valid;
    for (int i = 0; i < 40 && xfer_valid !== 1'b1; i++) tick(1);
    chk(73'(xfer_valid), 73'(1'b1));
  endtask : wait_valid

  //////////////////////////////////////////////////////////////////////////
  task automatic t_byte;
    int a0, t0;
    a0 = ack_cnt;
    t0 = tc_cnt;
    prog(3'h1, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0010, 16'h0001});
    lpc_req[1] = 1'b1;
    wait_valid();
    chk(73'({xfer.ch, xfer.byte_addr, xfer.wide}),
        73'({3'h1, 17'h10, 1'b0}));
    tick(20);
    lpc_req[1] = 1'b0;
    chk(73'(ack_cnt - a0), 73'(2));
    chk(73'(tc_cnt - t0), 73'(1));
    rd(3'h1);
    chk(73'({rd_data.cur_addr, rd_data.cfg.en}),
        73'({16'h0012, 1'b0}));
    chk(73'(rd_data.cur_cnt), 73'(16'hffff));
  endtask : t_byte

  task automatic t_word;
    int a0, lo;
    a0 = ack_cnt;
    lo = 0;
    slow = 1'b1;
    prog(3'h5, '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0008, 16'h0001});
    lpc_req[5] = 1'b1;
    wait_valid();
    chk(73'({xfer.ch, xfer.byte_addr, xfer.wide}),
        73'({3'h5, 17'h10, 1'b1}));
    // demand mode keeps the cycle requested until the last word
    for (int i = 0; i < 30; i++) begin
      tick(1);
      if (ack_cnt - a0 < 2 && xfer_valid !== 1'b1) lo++;
    end
    lpc_req[5] = 1'b0;
    chk(73'(lo), 73'(0));
    chk(73'(ack_cnt - a0), 73'(2));
    rd(3'h5);
    chk(73'(rd_data.cur_addr), 73'(16'h0006));
    chk(73'(rd_data.cur_cnt), 73'(16'hffff));
    slow = 1'b0;
  endtask : t_word

  task automatic t_bm;
    int a0;
    a0 = ack_cnt;
    prog(3'h4, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0003});
    lpc_req[4] = 1'b1;
    tick(3);
    chk(73'({bm_gnt, xfer_valid}), 73'(2'b10));
    lpc_req[4] = 1'b0;
    tick(3);
    chk(73'({bm_gnt, 8'(ack_cnt - a0)}), 73'(9'h0));
  endtask : t_bm

  task automatic t_pci;
    int a0, t0;
    a0 = ack_cnt;
    t0 = tc_cnt;
    prog(3'h6, '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0020, 16'h0000});
    pci_req[1] = '{1'b1, 3'h6};
    wait_valid();
    chk(73'({pci_gnt, xfer.from_pci, xfer.verify, xfer.ch}),
        73'(7'h5e));
    tick(10);
    pci_req = '0;
    chk(73'({8'(ack_cnt - a0), 8'(tc_cnt - t0), pci_gnt}),
        73'(18'h00404));
    prog(3'h7, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0003, 16'h0000});
    pci_req[0] = '{1'b1, 3'h7};
    wait_valid();
    chk(73'({pci_gnt, xfer.from_pci, xfer.ch, xfer.byte_addr}),
        73'({2'b01, 1'b1, 3'h7, 17'h00006}));
    tick(10);
    pci_req = '0;
    chk(73'({8'(tc_cnt - t0), pci_gnt}), 73'(10'h008));
  endtask : t_pci

  task automatic t_fast;
    int r0;
    r0 = ref_cnt;
    prog(3'h0, '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h1234, 16'h00ab});
    prog(3'h2, '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000});
    prog(3'h3, '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000});
    chk(73'(ref_cnt - r0), 73'(1));
    rd(3'h3);
    chk(73'(rd_data.cfg.fast), 73'(1'b0));
    rd(3'h0);
    chk(73'(rd_data.cfg), 73'(37'h08123400ab));
  endtask : t_fast

  task automatic t_restore;
    prog_ch     = 3'h2;
    prog_cfg    = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h5555, 16'h0077};
    prog_cur_we = 1'b1;
    tick(1);
    prog_cur_we = 1'b0;
    rd(3'h2);
    chk(73'({rd_data.cfg.fast, rd_data.cfg.addr, rd_data.cur_addr,
             rd_data.cur_cnt}), 73'({1'b1, 16'h0000, 16'h5555, 16'h0077}));
  endtask : t_restore

  initial begin
    {rst_n, prog_we, prog_cur_we, slow, prog_ch, rd_ch} = '0;
    {prog_cfg, lpc_req, pci_req} = '0;
    {fail_count, num_checks} = '0;
    tick(16);
    rst_n = 1'b1;
    rd(3'h0);
    chk({rd_data, xfer_valid, bm_gnt, pci_gnt}, 73'h0);
    t_byte();
    t_word();
    t_bm();
    t_pci();
    t_fast();
    t_restore();
    give_verdict();
  end

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule : dlc_dma_test

`default_nettype wire

// [dlc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dlc_host_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic xfer_valid,
  output logic      xfer_ack
);
  logic [2:0] wait_r;

  //////////////////////////////////////////////////////////////////////////
  // host runs the transfer cycle, then pulses ack for one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r   <= 3'h0;
      xfer_ack <= 1'b0;
    end else if (xfer_valid && !xfer_ack) begin
      wait_r   <= wait_r + 3'h1;
      xfer_ack <= (wait_r == (slow ? 3'h3 : 3'h0));
    end else begin
      wait_r   <= 3'h0;
      xfer_ack <= 1'b0;
    end
  end
endmodule : dlc_host_model

`default_nettype wire

// [dlc_pkg.sv]
`default_nettype none

package dlc_pkg;

  localparam int          DLC_NUM_CH   = 8;
  localparam int          DLC_CH_W     = 3;
  localparam int          DLC_ADDR_W   = 16;
  localparam int          DLC_NUM_PCI  = 2;
  localparam int          DLC_MAX_FAST = 2;
  localparam logic [2:0]  DLC_BM_CH    = 3'h4;
  localparam logic [2:0]  DLC_WIDE_LO  = 3'h5;
  localparam logic [15:0] DLC_RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    DLC_IDLE = 3'b001,
    DLC_XFER = 3'b010,
    DLC_BM   = 3'b100
  } dlc_state_e;

  // software-visible channel setup, read back and restored as a whole
  typedef struct packed {
    logic        en;
    logic        fast;
    logic        demand;
    logic        verify;
    logic        decr;
    logic [15:0] addr;
    logic [15:0] cnt;
  } dlc_cfg_s;

  typedef struct packed {
    dlc_cfg_s    cfg;
    logic [15:0] cur_addr;
    logic [15:0] cur_cnt;
  } dlc_rd_s;

  typedef struct packed {
    logic       req;
    logic [2:0] ch;
  } dlc_pci_req_s;

  typedef struct packed {
    logic [2:0]  ch;
    logic [16:0] byte_addr;
    logic        wide;
    logic        verify;
    logic        from_pci;
  } dlc_xfer_s;

endpackage : dlc_pkg

`default_nettype wire
